// [verilog/rsw_reset_watchdog.v]
// Reset source collector, reset cause register and watchdog timer.
// Assumes a synchronous special function register bus and synchronous inputs.
//
// Behaviour
// - Missing clock gap over 100 us resets
// - Missing clock flag bit 2, pin untouched
// - Missing clock detector needs its enable
// - Cause bit 5 write enables comparator reset
// - Comparator low resets, pin untouched
// - Comparator flag bit 5 after comparator reset
// - Cause bit 6 enables active-low convert reset
// - Convert flag bit 6 after convert reset
// - 21-bit watchdog expiry resets, pin untouched
// - Reset leaves watchdog running, interval 111b
// - Write a5 enables and restarts watchdog
// - de then ad within 4 clocks disables
// - Write ff locks disable, no restart
// - Timeout is 4 to (3 plus interval)
// - Interval written only when bit 7 clear
// - Watchdog control bit 4 reads running status
// - Cause bit 4 write forces internal reset
// - Cause bit 1 write forces power-on reset
// - Bit 3 flags watchdog reset cause
// - Bit 0 flags external pin reset
// - Power-on flag cleared by other resets
`timescale 1ns/1ps
`include "rsw_defs.vh"

module rsw_reset_watchdog #(
  parameter [19:0] POR_HOLD_CYC = `RSW_POR_HOLD_CYC
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire missing_clock_enable,
  input wire clk_present,
  input wire comparator_out,
  input wire convert_start_input_n,
  input wire rst_pin_in,
  output wire rst_pin_out,
  output reg rst_pin_oe_q,
  output reg sys_reset_n_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_PORDRV = 2'h2;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // One cause wins when several arrive together
  function [6:0] rsw_pick_cause;
    input [6:0] req;
    begin
      rsw_pick_cause = `RSW_CAUSE_NONE;
      if (req[`RSW_B_POR]) begin
        rsw_pick_cause[`RSW_B_POR] = 1'b1;
      end else if (req[`RSW_B_PIN]) begin
        rsw_pick_cause[`RSW_B_PIN] = 1'b1;
      end else if (req[`RSW_B_MCD]) begin
        rsw_pick_cause[`RSW_B_MCD] = 1'b1;
      end else if (req[`RSW_B_WDT]) begin
        rsw_pick_cause[`RSW_B_WDT] = 1'b1;
      end else if (req[`RSW_B_CMP]) begin
        rsw_pick_cause[`RSW_B_CMP] = 1'b1;
      end else if (req[`RSW_B_CNV]) begin
        rsw_pick_cause[`RSW_B_CNV] = 1'b1;
      end else if (req[`RSW_B_SW]) begin
        rsw_pick_cause[`RSW_B_SW] = 1'b1;
      end
    end
  endfunction

  // Last count before expiry: 4^(3+n) - 1
  function [20:0] rsw_wd_last;
    input [2:0] interval;
    reg [4:0] shift;
    begin
      shift = `RSW_WD_EXP_BASE + {interval, 1'b0};
      rsw_wd_last = (21'h000001 << shift) - 21'h000001;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] hold_q;
  reg [3:0] hold_d;
  reg [19:0] por_q;
  reg [19:0] por_d;
  reg [6:0] flags_q;
  reg [6:0] flags_d;
  reg cnv_en_q;
  reg cnv_en_d;
  reg cmp_en_q;
  reg cmp_en_d;
  reg wd_run_q;
  reg wd_run_d;
  reg wd_lock_q;
  reg wd_lock_d;
  reg [2:0] wd_int_q;
  reg [2:0] wd_int_d;
  reg [`RSW_WD_W-1:0] wd_cnt_q;
  reg [`RSW_WD_W-1:0] wd_cnt_d;
  reg wd_arm_q;
  reg wd_arm_d;
  reg [1:0] wd_gap_q;
  reg [1:0] wd_gap_d;
  reg [7:0] rdata_d;
  reg [6:0] req;
  reg [6:0] cause;
  wire running;
  wire wr_cause;
  wire wr_wdog;
  wire mcd_timeout;
  wire wd_expire;
  wire pin_low;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign running = (state_q == ST_RUN);
  assign wr_cause = running && sfr_wr && (sfr_addr == `RSW_ADDR_CAUSE);
  assign wr_wdog = running && sfr_wr && (sfr_addr == `RSW_ADDR_WDOG);
  // Our own drive of the pin must not read back as an external reset
  assign pin_low = !rst_pin_in && !rst_pin_oe_q;
  assign rst_pin_out = 1'b0;
  assign wd_expire = running && wd_run_q && (wd_cnt_q == rsw_wd_last(wd_int_q));

  // ----------------------------------------
  // Missing clock detector
  // ----------------------------------------
  rsw_missing_clock u_mcd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(missing_clock_enable && running),
    .clk_present(clk_present),
    .timeout_q(mcd_timeout)
  );

  // ----------------------------------------
  // Reset requests
  // ----------------------------------------
  always @* begin
    req = `RSW_CAUSE_NONE;
    req[`RSW_B_POR] = wr_cause && sfr_wdata[`RSW_B_POR];
    req[`RSW_B_PIN] = pin_low;
    req[`RSW_B_MCD] = running && mcd_timeout;
    req[`RSW_B_WDT] = wd_expire;
    req[`RSW_B_CMP] = running && cmp_en_q && !comparator_out;
    req[`RSW_B_CNV] = running && cnv_en_q && !convert_start_input_n;
    req[`RSW_B_SW] = wr_cause && sfr_wdata[`RSW_B_SW];
    cause = rsw_pick_cause(req);
  end

  // ----------------------------------------
  // Reset sequencer and cause flags
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    hold_d = hold_q;
    por_d = por_q;
    flags_d = flags_q;
    case (state_q)
      ST_RUN: begin
        if (cause != `RSW_CAUSE_NONE) begin
          // All flags load at once, so only one reads set
          flags_d = cause;
          if (cause[`RSW_B_POR]) begin
            state_d = ST_PORDRV;
            por_d = POR_HOLD_CYC;
          end else begin
            state_d = ST_HOLD;
            hold_d = `RSW_RST_HOLD_CYC;
          end
        end
      end
      ST_HOLD: begin
        if (pin_low) begin
          // Stay in reset until the pin has been released for a while
          hold_d = `RSW_RST_HOLD_CYC;
        end else if (hold_q == 4'h0) begin
          state_d = ST_RUN;
        end else begin
          hold_d = hold_q - 4'h1;
        end
      end
      ST_PORDRV: begin
        if (por_q == 20'h00000) begin
          state_d = ST_HOLD;
          hold_d = `RSW_RST_HOLD_CYC;
        end else begin
          por_d = por_q - 20'h00001;
        end
      end
      default: begin
        state_d = ST_HOLD;
        hold_d = `RSW_RST_HOLD_CYC;
      end
    endcase
  end

  // ----------------------------------------
  // Reset source enables
  // ----------------------------------------
  always @* begin
    cnv_en_d = cnv_en_q;
    cmp_en_d = cmp_en_q;
    if (!running || (cause != `RSW_CAUSE_NONE)) begin
      cnv_en_d = 1'b0;
      cmp_en_d = 1'b0;
    end else if (wr_cause) begin
      // Plain write sets both enables; flags never feed back
      cnv_en_d = sfr_wdata[`RSW_B_CNV];
      cmp_en_d = sfr_wdata[`RSW_B_CMP];
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always @* begin
    wd_run_d = wd_run_q;
    wd_lock_d = wd_lock_q;
    wd_int_d = wd_int_q;
    wd_cnt_d = wd_cnt_q;
    wd_arm_d = wd_arm_q;
    wd_gap_d = wd_gap_q;
    if (!running || (cause != `RSW_CAUSE_NONE)) begin
      wd_run_d = 1'b1;
      wd_lock_d = 1'b0;
      wd_int_d = `RSW_WD_INT_RST;
      wd_cnt_d = {`RSW_WD_W{1'b0}};
      wd_arm_d = 1'b0;
      wd_gap_d = 2'h0;
    end else begin
      if (wd_run_q) begin
        wd_cnt_d = wd_cnt_q + 21'h000001;
      end
      // Disable window closes four clocks after the first code
      if (wd_arm_q) begin
        if (wd_gap_q == `RSW_WD_GAP_LAST) begin
          wd_arm_d = 1'b0;
        end else begin
          wd_gap_d = wd_gap_q + 2'h1;
        end
      end
      if (wr_wdog) begin
        if (sfr_wdata == `RSW_WD_RESTART) begin
          wd_run_d = 1'b1;
          wd_cnt_d = {`RSW_WD_W{1'b0}};
        end else if (sfr_wdata == `RSW_WD_DIS1) begin
          wd_arm_d = 1'b1;
          wd_gap_d = 2'h0;
        end else if (sfr_wdata == `RSW_WD_DIS2) begin
          wd_arm_d = 1'b0;
          if (wd_arm_q && !wd_lock_q) begin
            wd_run_d = 1'b0;
            wd_cnt_d = {`RSW_WD_W{1'b0}};
          end
        end else if (sfr_wdata == `RSW_WD_LOCK) begin
          // Lock only; the count keeps running untouched
          wd_lock_d = 1'b1;
        end
        if (!sfr_wdata[`RSW_WD_B_ARM]) begin
          wd_int_d = sfr_wdata[2:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    rdata_d = sfr_rdata_q;
    if (sfr_rd) begin
      case (sfr_addr)
        `RSW_ADDR_CAUSE: begin
          rdata_d = {1'b0, flags_q};
        end
        `RSW_ADDR_WDOG: begin
          rdata_d = 8'h00;
          rdata_d[`RSW_WD_B_STAT] = wd_run_q;
          rdata_d[2:0] = wd_int_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_HOLD;
      hold_q <= `RSW_RST_HOLD_CYC;
      por_q <= 20'h00000;
      flags_q <= `RSW_CAUSE_POR;
      cnv_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      wd_run_q <= 1'b1;
      wd_lock_q <= 1'b0;
      wd_int_q <= `RSW_WD_INT_RST;
      wd_cnt_q <= {`RSW_WD_W{1'b0}};
      wd_arm_q <= 1'b0;
      wd_gap_q <= 2'h0;
      sfr_rdata_q <= 8'h00;
      rst_pin_oe_q <= 1'b0;
      sys_reset_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      por_q <= por_d;
      flags_q <= flags_d;
      cnv_en_q <= cnv_en_d;
      cmp_en_q <= cmp_en_d;
      wd_run_q <= wd_run_d;
      wd_lock_q <= wd_lock_d;
      wd_int_q <= wd_int_d;
      wd_cnt_q <= wd_cnt_d;
      wd_arm_q <= wd_arm_d;
      wd_gap_q <= wd_gap_d;
      sfr_rdata_q <= rdata_d;
      // Only the forced power-on reset pulls the pin
      rst_pin_oe_q <= (state_d == ST_PORDRV);
      sys_reset_n_q <= (state_d == ST_RUN);
    end
  end

endmodule

// [verilog/rsw_defs.vh]
// Constants for the reset source and watchdog block.
// Assumes a single 10 MHz system clock and byte-wide special function registers.
`ifndef RSW_DEFS_VH
`define RSW_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RSW_ADDR_CAUSE 8'hef
`define RSW_ADDR_WDOG 8'hff

// ----------------------------------------
// Reset cause register bit positions
// ----------------------------------------
`define RSW_B_PIN 0
`define RSW_B_POR 1
`define RSW_B_MCD 2
`define RSW_B_WDT 3
`define RSW_B_SW 4
`define RSW_B_CMP 5
`define RSW_B_CNV 6
`define RSW_CAUSE_POR 7'h02
`define RSW_CAUSE_NONE 7'h00

// ----------------------------------------
// Watchdog control codes and fields
// ----------------------------------------
`define RSW_WD_RESTART 8'ha5
`define RSW_WD_DIS1 8'hde
`define RSW_WD_DIS2 8'had
`define RSW_WD_LOCK 8'hff
`define RSW_WD_B_ARM 7
`define RSW_WD_B_STAT 4
`define RSW_WD_INT_RST 3'h7
`define RSW_WD_EXP_BASE 5'd6
`define RSW_WD_GAP_LAST 2'h3
`define RSW_WD_W 21

// ----------------------------------------
// Timing
// ----------------------------------------
// Sized to the counters that meet them; 100 us and 100 ms at 10 MHz
`define RSW_MCD_CYC 11'd1000
`define RSW_POR_HOLD_CYC 20'd1000000
`define RSW_RST_HOLD_CYC 4'hc

`endif

// [verilog/rsw_missing_clock.v]
// Missing clock one-shot for the reset source block.
// Assumes clk_present is low in each cycle the core clock is absent.
`timescale 1ns/1ps
`include "rsw_defs.vh"

module rsw_missing_clock (
  input wire sys_clk,
  input wire rst_n,
  input wire enable,
  input wire clk_present,
  output reg timeout_q
);

  reg [10:0] gap_q;
  reg [10:0] gap_d;
  reg timeout_d;

  // ----------------------------------------
  // Gap counter
  // ----------------------------------------
  always @* begin
    gap_d = gap_q;
    timeout_d = 1'b0;
    if (!enable || clk_present) begin
      gap_d = 11'h000;
    end else if (gap_q == `RSW_MCD_CYC) begin
      // Gap now exceeds the limit
      timeout_d = 1'b1;
      gap_d = 11'h000;
    end else begin
      gap_d = gap_q + 11'h001;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      gap_q <= 11'h000;
      timeout_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      timeout_q <= timeout_d;
    end
  end

endmodule

// [tb/rsw_props.sv]
// Checker for the reset source and watchdog block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps

module rsw_props (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire rst_pin_in,
  input wire rst_pin_oe_q,
  input wire sys_reset_n_q
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sw_wr;
    sys_reset_n_q && sfr_wr && sfr_addr == 8'hef && sfr_wdata[4];
  endsequence
  sequence s_por_wr;
    sys_reset_n_q && sfr_wr && sfr_addr == 8'hef && sfr_wdata[1];
  endsequence

  property p_sw;
    s_sw_wr |=> !sys_reset_n_q;
  endproperty
  property p_por;
    s_por_wr |-> ##[1:2] rst_pin_oe_q;
  endproperty
  property p_oe;
    rst_pin_oe_q |-> !sys_reset_n_q;
  endproperty
  property p_pin;
    sys_reset_n_q && !rst_pin_in && !rst_pin_oe_q |=> !sys_reset_n_q;
  endproperty
  property p_hold;
    $fell(sys_reset_n_q) |-> !sys_reset_n_q [*8];
  endproperty
  property p_rd_hold;
    !sfr_rd |=> $stable(sfr_rdata_q);
  endproperty
  property p_unmap;
    sys_reset_n_q && sfr_rd && sfr_addr != 8'hef && sfr_addr != 8'hff |=> sfr_rdata_q == 8'h00;
  endproperty
  property p_wd_rd;
    sys_reset_n_q && sfr_rd && sfr_addr == 8'hff |=> (sfr_rdata_q & 8'he8) == 8'h00;
  endproperty
  property p_cause;
    sys_reset_n_q && sfr_rd && sfr_addr == 8'hef |=> !sfr_rdata_q[7] && $onehot(sfr_rdata_q[6:0]);
  endproperty

  a_sw: assert property (p_sw) else $error("software reset missed");
  a_por: assert property (p_por) else $error("forced power-on not driving pin");
  a_oe: assert property (p_oe) else $error("pin driven outside reset");
  a_pin: assert property (p_pin) else $error("pin reset missed");
  a_hold: assert property (p_hold) else $error("internal reset too short");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed unread");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_wd_rd: assert property (p_wd_rd) else $error("watchdog read spare bits set");
  a_cause: assert property (p_cause) else $error("cause flags not one-hot");
endmodule

// [tb/rsw_reset_watchdog_tb.sv]
// Self-checking bench for the reset source and watchdog block.
// Assumes the reset pin is pulled up; besides the block, only t_pin drives it low, through pin_ext.
`timescale 1ns/1ps

module rsw_reset_watchdog_tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg missing_clock_enable = 1'b0;
  reg clk_present = 1'b1;
  reg comparator_out = 1'b1;
  reg convert_start_input_n = 1'b1;
  reg pin_ext = 1'b1;
  wire [7:0] sfr_rdata_q;
  wire rst_pin_out;
  wire rst_pin_oe_q;
  wire sys_reset_n_q;
  wire rst_pin_in = rst_pin_oe_q ? rst_pin_out : pin_ext;
  integer fail_count = 0;
  integer check_count = 0;
  integer n;

  // Short power-on hold keeps the forced case fast
  rsw_reset_watchdog #(.POR_HOLD_CYC(20'd20)) u_rsw_reset_watchdog (.sys_clk(sys_clk),
    .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .missing_clock_enable(missing_clock_enable), .clk_present(clk_present),
    .comparator_out(comparator_out), .convert_start_input_n(convert_start_input_n),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_q(rst_pin_oe_q),
    .sys_reset_n_q(sys_reset_n_q));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_of_test;
    begin
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Trailing idle cycle so no strobe is set twice in one step
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
      @(negedge sys_clk); sfr_wr = 1'b0;
      @(negedge sys_clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      sfr_addr = a; sfr_rd = 1'b1;
      @(negedge sys_clk); sfr_rd = 1'b0;
      @(negedge sys_clk); chk(sfr_rdata_q, e);
    end
  endtask
  task rst_lvl(input e);
    begin
      chk({7'h00, sys_reset_n_q}, {7'h00, e});
    end
  endtask
  task wait_lvl(input e, input integer lim);
    begin
      n = 0;
      while (sys_reset_n_q !== e && n < lim) begin
        @(negedge sys_clk); n = n + 1;
      end
      rst_lvl(e);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_boot;
    begin
      rd(8'hef, 8'h02);
      rd(8'hff, 8'h17);
      rd(8'h42, 8'h00);
    end
  endtask
  task t_sw;
    begin
      wr(8'hef, 8'h10); rst_lvl(1'b0);
      chk({7'h00, rst_pin_oe_q}, 8'h00);
      wait_lvl(1'b1, 200); rd(8'hef, 8'h10);
    end
  endtask
  task t_pin;
    begin
      pin_ext = 1'b0; repeat (3) @(negedge sys_clk); rst_lvl(1'b0);
      pin_ext = 1'b1; wait_lvl(1'b1, 200); rd(8'hef, 8'h01);
    end
  endtask
  // Both inputs low, only the enabled one may reset
  task t_src(input [7:0] en);
    begin
      comparator_out = 1'b0; convert_start_input_n = 1'b0;
      repeat (3) @(negedge sys_clk); rst_lvl(1'b1);
      wr(8'hef, en); rst_lvl(1'b0);
      chk({7'h00, rst_pin_oe_q}, 8'h00);
      comparator_out = 1'b1; convert_start_input_n = 1'b1;
      wait_lvl(1'b1, 200); rd(8'hef, en);
      comparator_out = 1'b0; convert_start_input_n = 1'b0;
      repeat (3) @(negedge sys_clk); rst_lvl(1'b1);
      comparator_out = 1'b1; convert_start_input_n = 1'b1;
    end
  endtask
  task t_mcd;
    begin
      clk_present = 1'b0; repeat (1100) @(negedge sys_clk); rst_lvl(1'b1);
      missing_clock_enable = 1'b1; wait_lvl(1'b0, 1200);
      chk({7'h00, n >= 1000 && n <= 1003}, 8'h01);
      chk({7'h00, rst_pin_oe_q}, 8'h00);
      clk_present = 1'b1; missing_clock_enable = 1'b0;
      wait_lvl(1'b1, 200); rd(8'hef, 8'h04);
    end
  endtask
  task t_wd;
    begin
      wr(8'hff, 8'h00); rd(8'hff, 8'h10);
      repeat (3) begin
        wr(8'hff, 8'ha5); repeat (40) @(negedge sys_clk);
      end
      rst_lvl(1'b1);
      wr(8'hff, 8'ha5); wait_lvl(1'b0, 300); chk(n[7:0], 8'd63);
      wait_lvl(1'b1, 200); rd(8'hef, 8'h08);
      rd(8'hff, 8'h17);
    end
  endtask
  task t_dis;
    begin
      wr(8'hff, 8'h00); wr(8'hff, 8'hde); repeat (2) @(negedge sys_clk);
      wr(8'hff, 8'had); rd(8'hff, 8'h00);
      repeat (100) @(negedge sys_clk); rst_lvl(1'b1);
      wr(8'hff, 8'ha5); rd(8'hff, 8'h10);
      wr(8'hff, 8'hde); repeat (3) @(negedge sys_clk);
      wr(8'hff, 8'had); wait_lvl(1'b0, 100);
      wait_lvl(1'b1, 200);
      wr(8'hff, 8'h00); wr(8'hff, 8'hff); wr(8'hff, 8'hde);
      wr(8'hff, 8'had); rd(8'hff, 8'h10);
      wait_lvl(1'b0, 100); wait_lvl(1'b1, 200);
    end
  endtask
  task t_por;
    begin
      wr(8'hef, 8'h02); repeat (3) @(negedge sys_clk);
      chk({7'h00, rst_pin_oe_q}, 8'h01);
      chk({7'h00, rst_pin_in}, 8'h00);
      wait_lvl(1'b1, 200); rd(8'hef, 8'h02);
    end
  endtask

  // ----------------------------------------
  // Run
  // ----------------------------------------
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Whole run is a few thousand cycles; this bound is ten times that
  initial begin
    #3000000;
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    wait_lvl(1'b1, 200);
    t_boot;
    t_sw;
    t_pin;
    t_src(8'h20);
    t_src(8'h40);
    t_mcd;
    t_wd;
    t_dis;
    t_por;
    end_of_test;
  end
endmodule

bind rsw_reset_watchdog rsw_props u_rsw_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata_q(sfr_rdata_q), .rst_pin_in(rst_pin_in), .rst_pin_oe_q(rst_pin_oe_q),
  .sys_reset_n_q(sys_reset_n_q));
